/* dsr_resp.sv */
`timescale 1ns/100ps
`default_nettype none

module dsr_resp
  import dsr_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dsr_pkg::DSR_WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // request acknowledge from slave
  input wire logic addr_ack_i,
  input wire logic req_abort_i,
  input wire logic req_rnw_i,
  input wire logic line_size_sel_i,
  input wire logic [dsr_pkg::DSR_BE_W-1:0] req_be_i,
  input wire logic slave_width_ind_i,
  // slave response
  input wire logic [dsr_pkg::DSR_BUS_W-1:0] slave_read_data_bus_i,
  input wire logic read_data_ack_i,
  input wire logic [2:0] read_word_order_i,
  input wire logic write_data_ack_i,
  input wire logic slave_busy_flag_i,
  input wire logic slave_error_flag_i,
  // write buffer load from the cache side
  input wire logic wbuf_we_i,
  input wire logic wbuf_dup_i,
  input wire logic [dsr_pkg::DSR_WIDX_W-1:0] wbuf_addr_i,
  input wire logic [dsr_pkg::DSR_WORD_W-1:0] wbuf_data_i,
  output logic [dsr_pkg::DSR_BUS_W-1:0] master_write_data_bus_o,
  // cache side results
  input wire logic barrier_req_i,
  output logic barrier_stall_o,
  output logic access_gate_o,
  output logic fill_valid_o,
  output logic fill_pair_o,
  output logic [2:0] fill_idx_o,
  output logic [dsr_pkg::DSR_BUS_W-1:0] fill_data_o,
  output logic single_valid_o,
  output logic [dsr_pkg::DSR_WORD_W-1:0] single_data_o,
  output logic machine_check_o
);
  import dsr_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] xfers(input logic line, input logic wide);
    xfers = line ? (wide ? DSR_XF_LINE_WIDE : DSR_XF_LINE_NARROW) : DSR_XF_SINGLE;
  endfunction

  function automatic logic [31:0] pick(input logic [63:0] bus, input logic [7:0] be);
    logic [31:0] w;
    logic [3:0] m;
    w = (|be[7:4]) ? bus[63:32] : bus[31:0];
    m = (|be[7:4]) ? be[7:4] : be[3:0];
    for (int i = 0; i < 4; i++) begin
      if (!m[i]) begin
        w[i*8 +: 8] = 8'h00;
      end
    end
    pick = w;
  endfunction

  logic gate_q, gate_d;
  logic rd_acc, wr_acc;

  // accesses only count once the gate opened and were not aborted
  assign rd_acc = addr_ack_i && !req_abort_i && req_rnw_i && gate_q;
  assign wr_acc = addr_ack_i && !req_abort_i && !req_rnw_i && gate_q;

  // ---------------------------------------------------------------
  // read return path
  // ---------------------------------------------------------------
  // two-slot queue: slot 0 is the request being answered
  logic [1:0] vld_q, vld_d, line_q, line_d, wide_q, wide_d;
  logic [15:0] be_q, be_d;
  logic [2:0] cnt_q, cnt_d;
  logic fv_d, fp_d, sv_d, order_bad;
  logic [2:0] fi_d;
  logic [63:0] fd_d;
  logic [31:0] sd_d;

  always_comb begin
    vld_d = vld_q;
    line_d = line_q;
    wide_d = wide_q;
    be_d = be_q;
    cnt_d = cnt_q;
    fv_d = 1'b0;
    fp_d = 1'b0;
    fi_d = fill_idx_o;
    fd_d = fill_data_o;
    sv_d = 1'b0;
    sd_d = single_data_o;
    order_bad = 1'b0;
    if (read_data_ack_i && vld_q[0]) begin
      if (!line_q[0]) begin
        sv_d = 1'b1;
        sd_d = pick(slave_read_data_bus_i, be_q[7:0]);
      end else if (wide_q[0]) begin
        if (read_word_order_i[0]) begin
          order_bad = 1'b1;
        end else begin
          fv_d = 1'b1;
          fp_d = 1'b1;
          fi_d = {read_word_order_i[2:1], 1'b0};
          fd_d = slave_read_data_bus_i;
        end
      end else begin
        fv_d = 1'b1;
        fi_d = read_word_order_i;
        fd_d = {read_word_order_i[0] ? slave_read_data_bus_i[31:0] :
                slave_read_data_bus_i[63:32], 32'h0000_0000};
      end
      if ({1'b0, cnt_q} == xfers(line_q[0], wide_q[0]) - 4'h1) begin
        vld_d = {1'b0, vld_q[1]};
        line_d = {1'b0, line_q[1]};
        wide_d = {1'b0, wide_q[1]};
        be_d = {8'h00, be_q[15:8]};
        cnt_d = 3'h0;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
    if (rd_acc) begin
      if (!vld_d[0]) begin
        vld_d[0] = 1'b1;
        line_d[0] = line_size_sel_i;
        wide_d[0] = slave_width_ind_i;
        be_d[7:0] = req_be_i;
      end else begin
        vld_d[1] = 1'b1;
        line_d[1] = line_size_sel_i;
        wide_d[1] = slave_width_ind_i;
        be_d[15:8] = req_be_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vld_q <= 2'h0;
      line_q <= 2'h0;
      wide_q <= 2'h0;
      be_q <= 16'h0000;
      cnt_q <= 3'h0;
      fill_valid_o <= 1'b0;
      fill_pair_o <= 1'b0;
      fill_idx_o <= 3'h0;
      fill_data_o <= 64'h0;
      single_valid_o <= 1'b0;
      single_data_o <= 32'h0;
    end else if (ce_i) begin
      vld_q <= vld_d;
      line_q <= line_d;
      wide_q <= wide_d;
      be_q <= be_d;
      cnt_q <= cnt_d;
      fill_valid_o <= fv_d;
      fill_pair_o <= fp_d;
      fill_idx_o <= fi_d;
      fill_data_o <= fd_d;
      single_valid_o <= sv_d;
      single_data_o <= sd_d;
    end
  end

  // ---------------------------------------------------------------
  // write data path
  // ---------------------------------------------------------------
  dsr_wr_e wst_q, wst_d;
  logic [2:0] wcnt_q, wcnt_d, widx_q, widx_d;
  logic [3:0] wtot_q, wtot_d;
  logic wwide_q, wwide_d;
  logic [31:0] wa_data, wb_data;

  always_comb begin
    wst_d = wst_q;
    wcnt_d = wcnt_q;
    widx_d = widx_q;
    wtot_d = wtot_q;
    wwide_d = wwide_q;
    case (wst_q)
      DSR_WR_IDLE: begin
        if (wr_acc) begin
          wtot_d = xfers(line_size_sel_i, slave_width_ind_i);
          wwide_d = slave_width_ind_i;
          wst_d = DSR_WR_SEND;
          // the first item may be taken in the address acknowledge cycle
          if (write_data_ack_i) begin
            if (wtot_d == DSR_XF_SINGLE) begin
              wst_d = DSR_WR_WAIT;
            end else begin
              wcnt_d = 3'h1;
              widx_d = slave_width_ind_i ? DSR_STEP_WIDE : DSR_STEP_NARROW;
            end
          end
        end
      end
      DSR_WR_SEND: begin
        if (write_data_ack_i) begin
          if ({1'b0, wcnt_q} == wtot_q - 4'h1) begin
            wst_d = DSR_WR_WAIT;
            wcnt_d = 3'h0;
            widx_d = 3'h0;
          end else begin
            wcnt_d = wcnt_q + 3'h1;
            widx_d = widx_q + (wwide_q ? DSR_STEP_WIDE : DSR_STEP_NARROW);
          end
        end
      end
      DSR_WR_WAIT: begin
        // target updated once busy falls
        if (!slave_busy_flag_i) begin
          wst_d = DSR_WR_IDLE;
        end
      end
      default: begin
        wst_d = DSR_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wst_q <= DSR_WR_IDLE;
      wcnt_q <= 3'h0;
      widx_q <= 3'h0;
      wtot_q <= DSR_XF_SINGLE;
      wwide_q <= 1'b0;
    end else if (ce_i) begin
      wst_q <= wst_d;
      wcnt_q <= wcnt_d;
      widx_q <= widx_d;
      wtot_q <= wtot_d;
      wwide_q <= wwide_d;
    end
  end

  // registered reads follow the next index, so data moves one cycle after ack
  dsr_wbuf #(
    .DW(DSR_WORD_W),
    .DEPTH(DSR_LINE_WORDS),
    .AW(DSR_WIDX_W)
  ) u_wbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .we_i(wbuf_we_i),
    .dup_i(wbuf_dup_i),
    .waddr_i(wbuf_addr_i),
    .wdata_i(wbuf_data_i),
    .raddr_a_i(widx_d),
    .raddr_b_i(widx_d + 3'h1),
    .rdata_a_o(wa_data),
    .rdata_b_o(wb_data)
  );

  assign master_write_data_bus_o = {wa_data, wb_data};

  // ---------------------------------------------------------------
  // gate, barrier, error and registers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d, rdat_q, rdat_d, dat_d;
  logic [15:0] ecnt_q, ecnt_d;
  logic oerr_q, oerr_d, berr_q, berr_d, ack_d, mc_d, err_move, pend;
  logic wb_req, wb_wr, stat_clr;

  assign pend = (|vld_q) || (wst_q != DSR_WR_IDLE);
  assign barrier_stall_o = barrier_req_i && (pend || slave_busy_flag_i);
  assign access_gate_o = gate_q;
  // late write errors still count while the write is outstanding
  assign err_move = slave_error_flag_i && (read_data_ack_i || write_data_ack_i ||
                    (slave_busy_flag_i && wst_q != DSR_WR_IDLE));
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land on the edge that samples ack, while the master still holds the request
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign stat_clr = wb_wr && wb_adr_i == DSR_STAT_OFS;

  always_comb begin
    gate_d = gate_q || !slave_busy_flag_i;
    mc_d = ctrl_q[DSR_CTRL_MCE_BIT] && err_move;
    ctrl_d = ctrl_q;
    rdat_d = sv_d ? sd_d : rdat_q;
    ecnt_d = err_move ? ecnt_q + 16'h0001 : ecnt_q;
    // a new event wins over a clear in the same cycle
    oerr_d = order_bad || (oerr_q && !(stat_clr && wb_dat_i[DSR_STAT_OERR_BIT]));
    berr_d = err_move || (berr_q && !(stat_clr && wb_dat_i[DSR_STAT_BERR_BIT]));
    ack_d = wb_req;
    dat_d = 32'h0000_0000;
    if (wb_wr && wb_adr_i == DSR_CTRL_OFS) begin
      ctrl_d[DSR_CTRL_MCE_BIT] = wb_dat_i[DSR_CTRL_MCE_BIT];
    end
    case (wb_adr_i)
      DSR_CTRL_OFS: dat_d = ctrl_q;
      DSR_STAT_OFS: begin
        dat_d[DSR_STAT_GATE_BIT] = gate_q;
        dat_d[DSR_STAT_BUSY_BIT] = slave_busy_flag_i;
        dat_d[DSR_STAT_OERR_BIT] = oerr_q;
        dat_d[DSR_STAT_BERR_BIT] = berr_q;
        dat_d[DSR_STAT_WPEND_BIT] = (wst_q != DSR_WR_IDLE);
        dat_d[DSR_STAT_RPEND_LSB +: 2] = vld_q;
      end
      DSR_RDATA_OFS: dat_d = rdat_q;
      DSR_ECNT_OFS: dat_d = {16'h0000, ecnt_q};
      default: dat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gate_q <= 1'b0;
      machine_check_o <= 1'b0;
      ctrl_q <= DSR_CTRL_RST;
      rdat_q <= 32'h0000_0000;
      ecnt_q <= 16'h0000;
      oerr_q <= 1'b0;
      berr_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      gate_q <= gate_d;
      machine_check_o <= mc_d;
      ctrl_q <= ctrl_d;
      rdat_q <= rdat_d;
      ecnt_q <= ecnt_d;
      oerr_q <= oerr_d;
      berr_q <= berr_d;
      wb_ack_o <= ack_d;
      wb_dat_o <= dat_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  no_ack_nodata_a: assert property (ce_i && !read_data_ack_i |=>
    !fill_valid_o && !single_valid_o) else $error("read result without acknowledge");
  wide_pair_a: assert property (ce_i && read_data_ack_i && vld_q[0] && line_q[0]
    && wide_q[0] && !read_word_order_i[0] |=> fill_pair_o
    && fill_data_o == $past(slave_read_data_bus_i)) else $error("wide doubleword lost");
  narrow_sel_a: assert property (ce_i && read_data_ack_i && vld_q[0] && line_q[0]
    && !wide_q[0] |=> fill_valid_o && !fill_pair_o && fill_idx_o == $past(read_word_order_i))
    else $error("narrow word index wrong");
  order_bad_a: assert property (ce_i && read_data_ack_i && vld_q[0] && line_q[0]
    && wide_q[0] && read_word_order_i[0] |=> !fill_valid_o && oerr_q)
    else $error("invalid order accepted");
  single_pick_a: assert property (ce_i && read_data_ack_i && vld_q[0] && !line_q[0]
    && be_q[7:0] == 8'hF0 |=> single_valid_o && !fill_valid_o
    && single_data_o == $past(slave_read_data_bus_i[63:32]))
    else $error("single word select wrong");
  wdata_hold_a: assert property (ce_i && wst_q == DSR_WR_SEND && !write_data_ack_i
    && !wbuf_we_i |=> $stable(master_write_data_bus_o)) else $error("write data moved early");
  barrier_a: assert property (barrier_req_i && (slave_busy_flag_i || |vld_q)
    |-> barrier_stall_o) else $error("barrier released while busy");
  gate_open_a: assert property ($rose(access_gate_o) |-> !$past(slave_busy_flag_i))
    else $error("gate opened while busy");
  mcheck_a: assert property (ce_i && ctrl_q[DSR_CTRL_MCE_BIT] && slave_error_flag_i
    && read_data_ack_i |=> machine_check_o) else $error("machine check missed");
  wb_ack_pulse_a: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule
`default_nettype wire

/* dsr_pkg.sv */
package dsr_pkg;

  // ---------------------------------------------------------------
  // data path widths
  // ---------------------------------------------------------------
  localparam int DSR_BUS_W = 64;
  localparam int DSR_WORD_W = 32;
  localparam int DSR_BE_W = 8;
  localparam int DSR_LINE_WORDS = 8;
  localparam int DSR_WIDX_W = 3;

  // ---------------------------------------------------------------
  // transfer counts per request
  // ---------------------------------------------------------------
  localparam logic [3:0] DSR_XF_SINGLE = 4'h1;
  localparam logic [3:0] DSR_XF_LINE_NARROW = 4'h8;
  localparam logic [3:0] DSR_XF_LINE_WIDE = 4'h4;
  localparam logic [2:0] DSR_STEP_NARROW = 3'h1;
  localparam logic [2:0] DSR_STEP_WIDE = 3'h2;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int DSR_WB_AW = 5;
  localparam logic [4:0] DSR_CTRL_OFS = 5'h00;
  localparam logic [4:0] DSR_STAT_OFS = 5'h04;
  localparam logic [4:0] DSR_RDATA_OFS = 5'h08;
  localparam logic [4:0] DSR_ECNT_OFS = 5'h0C;

  localparam int DSR_CTRL_MCE_BIT = 0;
  localparam logic [31:0] DSR_CTRL_RST = 32'h0000_0000;
  localparam int DSR_STAT_GATE_BIT = 0;
  localparam int DSR_STAT_BUSY_BIT = 1;
  localparam int DSR_STAT_OERR_BIT = 2;
  localparam int DSR_STAT_BERR_BIT = 3;
  localparam int DSR_STAT_WPEND_BIT = 4;
  localparam int DSR_STAT_RPEND_LSB = 8;

  // ---------------------------------------------------------------
  // write-side state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DSR_WR_IDLE = 2'b00,
    DSR_WR_SEND = 2'b01,
    DSR_WR_WAIT = 2'b10
  } dsr_wr_e;

endpackage

/* dsr_wbuf.sv */
`timescale 1ns/100ps
`default_nettype none

module dsr_wbuf #(
  parameter int DW = 32,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // write port
  input wire logic we_i,
  input wire logic dup_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // two read ports, registered
  input wire logic [AW-1:0] raddr_a_i,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [DW-1:0] rdata_a_o,
  output logic [DW-1:0] rdata_b_o
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] pair_addr;

  // dup writes the partner entry too, so a single word appears on both halves
  assign pair_addr = waddr_i ^ {{(AW-1){1'b0}}, 1'b1};

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_q[waddr_i] <= wdata_i;
      if (dup_i) begin
        mem_q[pair_addr] <= wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else if (ce_i) begin
      rdata_a_o <= mem_q[raddr_a_i];
      rdata_b_o <= mem_q[raddr_b_i];
    end
  end

endmodule
`default_nettype wire

/* dsr_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// far-side slave: one request at a time, gaps set by the bench
// ---------------------------------------------------------------
module dsr_slave_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // command from the bench
  input wire logic start_i,
  input wire logic rnw_i,
  input wire logic line_i,
  input wire logic wide_i,
  input wire logic bad_i,
  input wire logic err_i,
  input wire logic pre_busy_i,
  input wire logic [1:0] gap_i,
  input wire logic [2:0] first_i,
  input wire logic [31:0] base_i,
  // slave side of the port
  output logic addr_ack_o,
  output logic width_o,
  output logic [63:0] rd_bus_o,
  output logic rd_ack_o,
  output logic [2:0] order_o,
  output logic wr_ack_o,
  output logic busy_o,
  output logic err_o,
  output logic active_o
);
  logic busy_q;
  logic [31:0] err_addr_q;
  logic [2:0] idx;
  int n;
  int k;
  int g;
  // pre_busy stands for traffic begun before a core reset
  assign busy_o = busy_q | pre_busy_i;

  function automatic logic [31:0] wd(input logic [31:0] b, input logic [2:0] i);
    return b ^ {4{5'h00, i}};
  endfunction

  // released lines move in each gap cycle and once after the last item, so stale data never looks valid
  task automatic idle();
    rd_ack_o <= 1'b0;
    wr_ack_o <= 1'b0;
    err_o <= 1'b0;
    rd_bus_o <= ~rd_bus_o;
    order_o <= order_o + 3'h3;
  endtask

  initial begin
    {addr_ack_o, width_o, rd_ack_o, wr_ack_o, err_o, busy_q, active_o} = 7'h00;
    rd_bus_o = 64'h0;
    order_o = 3'h0;
    err_addr_q = 32'h0000_0000;
    forever begin
      @(posedge clk_i);
      if (start_i && !rst_i) begin
        active_o <= 1'b1;
        if (err_i) err_addr_q <= base_i;
        n = !line_i ? 1 : (wide_i ? 4 : 8);
        addr_ack_o <= 1'b1;
        width_o <= wide_i;
        wr_ack_o <= !rnw_i;
        k = rnw_i ? 0 : 1;
        g = gap_i;
        @(posedge clk_i);
        addr_ack_o <= 1'b0;
        width_o <= ~wide_i;
        busy_q <= 1'b1;
        while (k < n) begin
          if (g != 0) begin
            idle();
            g--;
          end else begin
            idx = wide_i ? {first_i[2:1], 1'b0} + 3'(2 * k) : first_i + 3'(k);
            rd_ack_o <= rnw_i;
            wr_ack_o <= !rnw_i;
            err_o <= rnw_i && err_i && k == 0;
            order_o <= !line_i ? ~first_i : {idx[2:1], wide_i ? (bad_i && k == 1) : idx[0]};
            rd_bus_o <= wide_i ? {wd(base_i, {idx[2:1], 1'b0}), wd(base_i, {idx[2:1], 1'b1})}
                               : {2{wd(base_i, idx)}};
            k++;
            g = gap_i;
          end
          @(posedge clk_i);
        end
        idle();
        if (!rnw_i) begin
          // a write fault is seen late, after the data, but still under busy
          @(posedge clk_i);
          err_o <= err_i;
          @(posedge clk_i);
          err_o <= 1'b0;
        end
        busy_q <= 1'b0;
        active_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* data_side_bus_response_path_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module data_side_bus_response_path_tb;
  import dsr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i, cyc, stb, we, addr_ack, rnw, line, wid, rd_ack, wr_ack, busy, err;
  logic wbuf_we, bar_req, bar_stall, gate, f_valid, f_pair, s_valid, mc, ack;
  logic start, wide, bad, err_cmd, pre_busy, active, mce;
  logic p_rd, p_err, p_line, p_wide, lw;
  logic [1:0] gap;
  logic [2:0] order, wb_a, f_idx, first, p_ord;
  logic [3:0] sel;
  logic [4:0] adr;
  logic [7:0] be;
  logic [31:0] dat_w, dat_r, wb_d, s_data, base, rd, r;
  logic [31:0] seed = 32'h0000005C;
  logic [31:0] ebase = 32'h0000_0000;
  logic [31:0] wmem [8];
  logic [63:0] rd_bus, wr_bus, f_data, rd_bus_q;
  int num_errors = 0;
  int n_compared = 0;
  int wr_k;

  always #2.5 clk_i = ~clk_i;

  dsr_resp u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .addr_ack_i(addr_ack), .req_abort_i(1'b0), .req_rnw_i(rnw),
    .line_size_sel_i(line), .req_be_i(be), .slave_width_ind_i(wid),
    .slave_read_data_bus_i(rd_bus), .read_data_ack_i(rd_ack), .read_word_order_i(order),
    .write_data_ack_i(wr_ack), .slave_busy_flag_i(busy), .slave_error_flag_i(err),
    .wbuf_we_i(wbuf_we), .wbuf_dup_i(1'b0), .wbuf_addr_i(wb_a), .wbuf_data_i(wb_d),
    .master_write_data_bus_o(wr_bus), .barrier_req_i(bar_req), .barrier_stall_o(bar_stall),
    .access_gate_o(gate), .fill_valid_o(f_valid), .fill_pair_o(f_pair), .fill_idx_o(f_idx),
    .fill_data_o(f_data), .single_valid_o(s_valid), .single_data_o(s_data),
    .machine_check_o(mc));

  dsr_slave_model u_slv (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .rnw_i(rnw),
    .line_i(line), .wide_i(wide), .bad_i(bad), .err_i(err_cmd), .pre_busy_i(pre_busy),
    .gap_i(gap), .first_i(first), .base_i(base), .addr_ack_o(addr_ack), .width_o(wid),
    .rd_bus_o(rd_bus), .rd_ack_o(rd_ack), .order_o(order), .wr_ack_o(wr_ack), .busy_o(busy),
    .err_o(err), .active_o(active));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] wd(input logic [31:0] b, input logic [2:0] i);
    return b ^ {4{5'h00, i}};
  endfunction

  // the enabled nibble picks the half, disabled bytes read as zero
  function automatic logic [31:0] sel_word(input logic [63:0] bus, input logic [7:0] e);
    logic [3:0] m;
    m = (e[7:4] != 4'h0) ? e[7:4] : e[3:0];
    return ((e[7:4] != 4'h0) ? bus[63:32] : bus[31:0])
           & {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("mismatches %0d of %0d compared", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // classic cycle: hold everything until ack is sampled, then idle one cycle
  task automatic wb_xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = dat_r;
    if (t == 50) num_errors++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic xact(input logic rw, input logic ln, input logic wi, input logic bo,
                      input logic er);
    int t;
    logic [31:0] eb;
    r = rnd();
    rnw <= rw;
    line <= ln;
    wide <= wi;
    bad <= bo;
    err_cmd <= er;
    gap <= r[1:0];
    first <= r[4:2];
    eb = rnd();
    base <= eb;
    if (er) ebase = eb;
    // full upper lanes come up often so the upper-word select is exercised
    be <= r[5] ? {((r[9:6] == 4'h0 || r[10]) ? 4'hF : r[9:6]), 4'h0} : {4'h0, r[9:6] | 4'h1};
    start <= 1'b1;
    wr_k = 0;
    @(posedge clk_i);
    start <= 1'b0;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (active !== 1'b0 && t < 200);
    if (t == 200) num_errors++;
    repeat (2) @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // monitor: results are due one cycle after the acknowledge
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_i && gate === 1'b1) begin
      lw = p_wide && p_ord[0];
      if (p_rd && p_line) begin
        chk("fill valid", !lw, f_valid);
        if (!lw) begin
          chk("fill idx", p_wide ? {p_ord[2:1], 1'b0} : p_ord, f_idx);
          chk("fill pair", p_wide, f_pair);
          chk("fill data", p_wide ? {wd(base, {p_ord[2:1], 1'b0}), wd(base, {p_ord[2:1], 1'b1})}
                                  : {wd(base, p_ord), 32'h0}, f_data);
        end
      end else if (p_rd) begin
        chk("single valid", 1'b1, s_valid);
        chk("single data", sel_word(rd_bus_q, be), s_data);
      end else begin
        chk("idle fill", 1'b0, f_valid | s_valid);
      end
      chk("machine check", p_err && mce, mc);
      if (wr_ack && !rnw) begin
        if (wide) chk("write pair", {wmem[2 * wr_k], wmem[2 * wr_k + 1]}, wr_bus);
        else chk("write word", wmem[wr_k], wr_bus[63:32]);
        wr_k++;
      end
      if (bar_req && busy) chk("barrier busy", 1'b1, bar_stall);
    end
    p_rd = rd_ack;
    p_err = err;
    p_ord = order;
    p_line = line;
    p_wide = wide;
    rd_bus_q = rd_bus;
  end

  // a full run needs roughly a thousand cycles or fewer; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    summarize();
  end

  initial begin
    {cyc, stb, we, wbuf_we, bar_req, start, wide, bad, err_cmd, rnw, line, mce} = 12'h000;
    {adr, sel, dat_w, wb_a, wb_d, be, gap, first, base} = '0;
    pre_busy = 1'b1;
    rst_i = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("gate while busy", 1'b0, gate);
    pre_busy <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("gate after idle", 1'b1, gate);
    wb_xfer(1'b0, DSR_CTRL_OFS, 32'h0);
    chk("ctrl reset", DSR_CTRL_RST, rd);
    wb_xfer(1'b1, 5'h14, 32'hFFFFFFFF);
    wb_xfer(1'b0, 5'h14, 32'h0);
    chk("unmapped read", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      wmem[i] = rnd();
      wbuf_we <= 1'b1;
      wb_a <= 3'(i);
      wb_d <= wmem[i];
      @(posedge clk_i);
    end
    wbuf_we <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 28; i++) begin
      if (i == 14) begin
        wb_xfer(1'b1, DSR_CTRL_OFS, 32'h1);
        mce = 1'b1;
      end
      r = rnd();
      bar_req <= r[5];
      if (i < 4) xact(i[1], 1'b1, i[0], 1'b0, i == 2);
      else xact(r[0], r[1], r[2], 1'b0, r[4:3] == 2'h0 || i == 15);
      if (bar_req) chk("barrier idle", 1'b0, bar_stall);
    end
    xact(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    wb_xfer(1'b0, DSR_STAT_OFS, 32'h0);
    chk("order flag", 1'b1, rd[DSR_STAT_OERR_BIT]);
    chk("error flag", 1'b1, rd[DSR_STAT_BERR_BIT]);
    chk("error address", ebase, u_slv.err_addr_q);
    wb_xfer(1'b1, DSR_STAT_OFS, 32'h0000_000C);
    wb_xfer(1'b0, DSR_STAT_OFS, 32'h0000_0000);
    chk("flags cleared", 2'h0, rd[DSR_STAT_BERR_BIT:DSR_STAT_OERR_BIT]);
    summarize();
  end
endmodule
`default_nettype wire
